//--- rtl/prog_flag_unit.sv
// programmable almost-full / almost-empty flag unit with offset loading
`timescale 1ns/1ps

module prog_flag_unit (
  input wire logic i_sys_clk,
  input wire logic i_resetn,
  input wire logic i_clk_en,
  input wire logic i_master_reset_n,
  input wire logic i_flag_timing_select,
  input wire logic i_fall_through_timing,
  input wire logic i_x9_in,
  input wire logic i_x9_out,
  input wire logic i_async_read_req,
  input wire logic [2:0] i_depth_sel,
  input wire logic i_wr_clk,
  input wire logic i_rd_clk,
  input wire logic i_wr_en_n,
  input wire logic i_rd_en_n,
  input wire logic i_load_n,
  input wire logic i_serial_en_n,
  input wire logic i_serial_in,
  input wire logic [17:0] i_wr_data,
  input wire logic [4:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr_stb,
  input wire logic i_rd_stb,
  output logic [31:0] o_rdata,
  output logic [17:0] o_ofs_data,
  output logic o_almost_full_flag_n,
  output logic o_almost_empty_flag_n,
  output logic o_async_read_active,
  output logic o_irq
);

  // ==========================================================
  // pin synchronisers
  // ==========================================================
  logic [prog_flag_pkg::PIN_W-1:0] pin_s1_r, pin_s2_r, pin_s3_r, pin_in;
  assign pin_in = {i_wr_data, i_depth_sel, i_serial_in, i_serial_en_n,
                   i_load_n, i_rd_en_n, i_wr_en_n, i_rd_clk, i_wr_clk,
                   i_async_read_req, i_x9_out, i_x9_in,
                   i_fall_through_timing, i_flag_timing_select,
                   i_master_reset_n};

  // s1 feeds s2 only; s3 exists for edge detection of clocks
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      pin_s1_r <= '0;
      pin_s2_r <= '0;
      pin_s3_r <= '0;
    end else if (i_clk_en) begin
      pin_s1_r <= pin_in;
      pin_s2_r <= pin_s1_r;
      pin_s3_r <= pin_s2_r;
    end
  end

  logic mrst_act, wedge, redge, ld_n, sen_n;
  logic [prog_flag_pkg::DATA_W-1:0] din;
  logic [prog_flag_pkg::DSEL_W-1:0] dsel;
  assign mrst_act = !pin_s2_r[prog_flag_pkg::P_MRST];
  assign wedge = i_clk_en && pin_s2_r[prog_flag_pkg::P_WCLK] &&
                 !pin_s3_r[prog_flag_pkg::P_WCLK];
  assign redge = i_clk_en && pin_s2_r[prog_flag_pkg::P_RCLK] &&
                 !pin_s3_r[prog_flag_pkg::P_RCLK];
  assign ld_n = pin_s2_r[prog_flag_pkg::P_LD];
  assign sen_n = pin_s2_r[prog_flag_pkg::P_SEN];
  assign din = pin_s2_r[prog_flag_pkg::P_DATA +: prog_flag_pkg::DATA_W];
  assign dsel = pin_s2_r[prog_flag_pkg::P_DSEL +: prog_flag_pkg::DSEL_W];

  // ==========================================================
  // mode capture at master reset
  // ==========================================================
  logic tsel_r, fall_r, x9both_r, asrd_r;
  logic [prog_flag_pkg::DSEL_W-1:0] dsel_r;

  // straps follow the pins while master reset is held, freeze after
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      tsel_r <= 1'b0;
      fall_r <= 1'b0;
      x9both_r <= 1'b0;
      asrd_r <= 1'b0;
      dsel_r <= '0;
    end else if (i_clk_en && mrst_act) begin
      tsel_r <= pin_s2_r[prog_flag_pkg::P_FTSEL];
      fall_r <= pin_s2_r[prog_flag_pkg::P_FALL];
      x9both_r <= pin_s2_r[prog_flag_pkg::P_X9IN] &&
                  pin_s2_r[prog_flag_pkg::P_X9OUT];
      asrd_r <= pin_s2_r[prog_flag_pkg::P_ASRD];
      dsel_r <= dsel;
    end
  end

  // fall-through needs a clocked read port
  assign o_async_read_active = asrd_r && !fall_r;

  // ==========================================================
  // depth and serial bit count
  // ==========================================================
  logic [prog_flag_pkg::CNT_W-1:0] depth_d;
  logic [prog_flag_pkg::BIT_W-1:0] ser_bits;
  assign depth_d = ((x9both_r ? prog_flag_pkg::DEPTH_BASE_X9 :
                     prog_flag_pkg::DEPTH_BASE_X18) << dsel_r) +
                   {{(prog_flag_pkg::CNT_W-1){1'b0}}, fall_r};
  assign ser_bits = (x9both_r ? prog_flag_pkg::SER_BITS_X9 :
                     prog_flag_pkg::SER_BITS_OTHER) +
                    {2'h0, dsel_r};

  // ==========================================================
  // word level
  // ==========================================================
  logic [prog_flag_pkg::CNT_W-1:0] level_r, level_nxt;
  logic wr_ev, rd_ev, ovf_ev;
  assign wr_ev = wedge && ld_n && !pin_s2_r[prog_flag_pkg::P_WEN] &&
                 (level_r != depth_d);
  assign ovf_ev = wedge && ld_n && !pin_s2_r[prog_flag_pkg::P_WEN] &&
                  (level_r == depth_d);
  assign rd_ev = redge && ld_n && !pin_s2_r[prog_flag_pkg::P_REN] &&
                 (level_r != '0);

  always_comb begin
    level_nxt = level_r;
    if (wr_ev && !rd_ev) begin
      level_nxt = level_r + 18'h00001;
    end else if (rd_ev && !wr_ev) begin
      level_nxt = level_r - 18'h00001;
    end
  end

  // level cleared by master reset
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      level_r <= '0;
    end else if (i_clk_en) begin
      level_r <= mrst_act ? '0 : level_nxt;
    end
  end

  // ==========================================================
  // offset programming, serial and parallel
  // ==========================================================
  logic [prog_flag_pkg::CNT_W-1:0] empty_ofs_r, full_ofs_r;
  logic [prog_flag_pkg::BIT_W-1:0] bit_r;
  logic ser_half_r, load_done;
  logic [prog_flag_pkg::STEP_W-1:0] wstep_r, rstep_r, par_last;
  logic ser_ev, par_ev, prd_ev;
  assign ser_ev = wedge && !ld_n && !sen_n;
  assign par_ev = wedge && !ld_n && sen_n &&
                  !pin_s2_r[prog_flag_pkg::P_WEN];
  assign prd_ev = redge && !ld_n && !pin_s2_r[prog_flag_pkg::P_REN];
  assign par_last = x9both_r ? prog_flag_pkg::PAR_LAST_X9 :
                    prog_flag_pkg::PAR_LAST_X18;
  assign load_done = (ser_ev && ser_half_r &&
                      bit_r == ser_bits - 5'h01) ||
                     (par_ev && wstep_r == par_last);

  // serial bits arrive lsb first; empty offset then full offset
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      empty_ofs_r <= prog_flag_pkg::OFS_DEFAULT;
      full_ofs_r <= prog_flag_pkg::OFS_DEFAULT;
      bit_r <= '0;
      ser_half_r <= 1'b0;
      wstep_r <= '0;
    end else if (i_clk_en && mrst_act) begin
      empty_ofs_r <= prog_flag_pkg::OFS_DEFAULT;
      full_ofs_r <= prog_flag_pkg::OFS_DEFAULT;
      bit_r <= '0;
      ser_half_r <= 1'b0;
      wstep_r <= '0;
    end else if (ser_ev) begin
      if (ser_half_r) begin
        full_ofs_r[bit_r] <= pin_s2_r[prog_flag_pkg::P_SIN];
      end else begin
        empty_ofs_r[bit_r] <= pin_s2_r[prog_flag_pkg::P_SIN];
      end
      if (bit_r == ser_bits - 5'h01) begin
        bit_r <= '0;
        ser_half_r <= !ser_half_r;
      end else begin
        bit_r <= bit_r + 5'h01;
      end
    end else if (par_ev) begin
      // x9 takes low half then high half of each offset
      if (!x9both_r) begin
        if (wstep_r == 2'h0) empty_ofs_r <= din;
        else full_ofs_r <= din;
      end else begin
        unique case (wstep_r)
          2'h0: empty_ofs_r[0 +: prog_flag_pkg::BYTE_W] <= din[8:0];
          2'h1: empty_ofs_r[9 +: prog_flag_pkg::BYTE_W] <= din[8:0];
          2'h2: full_ofs_r[0 +: prog_flag_pkg::BYTE_W] <= din[8:0];
          2'h3: full_ofs_r[9 +: prog_flag_pkg::BYTE_W] <= din[8:0];
        endcase
      end
      wstep_r <= (wstep_r == par_last) ? 2'h0 : wstep_r + 2'h1;
    end
  end

  // parallel read walks the same steps on read edges
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rstep_r <= '0;
      o_ofs_data <= '0;
    end else if (i_clk_en && mrst_act) begin
      rstep_r <= '0;
    end else if (prd_ev) begin
      if (!x9both_r) begin
        o_ofs_data <= (rstep_r == 2'h0) ? empty_ofs_r : full_ofs_r;
      end else begin
        unique case (rstep_r)
          2'h0: o_ofs_data <= {9'h000, empty_ofs_r[8:0]};
          2'h1: o_ofs_data <= {9'h000, empty_ofs_r[17:9]};
          2'h2: o_ofs_data <= {9'h000, full_ofs_r[8:0]};
          2'h3: o_ofs_data <= {9'h000, full_ofs_r[17:9]};
        endcase
      end
      rstep_r <= (rstep_r == par_last) ? 2'h0 : rstep_r + 2'h1;
    end
  end

  // ==========================================================
  // programmable flags
  // ==========================================================
  logic full_cond, empty_cond;
  assign full_cond = (depth_d - level_nxt) <= full_ofs_r;
  assign empty_cond = level_nxt <= empty_ofs_r;

  // sync mode samples on own clock; async sets/clears on opposite edges
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_almost_full_flag_n <= 1'b1;
    end else if (i_clk_en && mrst_act) begin
      o_almost_full_flag_n <= 1'b1;
    end else if (tsel_r) begin
      if (wedge) o_almost_full_flag_n <= !full_cond;
    end else if (wedge && full_cond) begin
      o_almost_full_flag_n <= 1'b0;
    end else if (redge && !full_cond) begin
      o_almost_full_flag_n <= 1'b1;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_almost_empty_flag_n <= 1'b0;
    end else if (i_clk_en && mrst_act) begin
      o_almost_empty_flag_n <= 1'b0;
    end else if (tsel_r) begin
      if (redge) o_almost_empty_flag_n <= !empty_cond;
    end else if (redge && empty_cond) begin
      o_almost_empty_flag_n <= 1'b0;
    end else if (wedge && !empty_cond) begin
      o_almost_empty_flag_n <= 1'b1;
    end
  end

  // ==========================================================
  // interrupts and register port
  // ==========================================================
  logic [prog_flag_pkg::IRQ_W-1:0] irq_stat_r, irq_mask_r, irq_set;
  logic afull_d_r, aempty_d_r;
  logic [31:0] rdata_nxt;

  // delayed flags give the falling-edge events
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      afull_d_r <= 1'b1;
      aempty_d_r <= 1'b0;
    end else if (i_clk_en) begin
      afull_d_r <= o_almost_full_flag_n;
      aempty_d_r <= o_almost_empty_flag_n;
    end
  end

  assign irq_set = {ovf_ev, load_done,
                    aempty_d_r && !o_almost_empty_flag_n,
                    afull_d_r && !o_almost_full_flag_n};

  // set beats a same-cycle write-one clear
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      irq_stat_r <= '0;
      irq_mask_r <= '0;
    end else if (i_clk_en) begin
      if (i_wr_stb && i_addr == prog_flag_pkg::REG_IRQ_MASK) begin
        irq_mask_r <= i_wdata[prog_flag_pkg::IRQ_W-1:0];
      end
      if (i_wr_stb && i_addr == prog_flag_pkg::REG_IRQ_STAT) begin
        irq_stat_r <= (irq_stat_r & ~i_wdata[prog_flag_pkg::IRQ_W-1:0]) |
                      irq_set;
      end else begin
        irq_stat_r <= irq_stat_r | irq_set;
      end
    end
  end

  assign o_irq = |(irq_stat_r & irq_mask_r);

  always_comb begin
    rdata_nxt = '0;
    unique case (i_addr)
      prog_flag_pkg::REG_STATUS: rdata_nxt[6:0] = {o_async_read_active,
        asrd_r, x9both_r, fall_r, tsel_r, o_almost_empty_flag_n,
        o_almost_full_flag_n};
      prog_flag_pkg::REG_LEVEL: rdata_nxt[17:0] = level_r;
      prog_flag_pkg::REG_EMPTY_OFS: rdata_nxt[17:0] = empty_ofs_r;
      prog_flag_pkg::REG_FULL_OFS: rdata_nxt[17:0] = full_ofs_r;
      prog_flag_pkg::REG_IRQ_STAT: rdata_nxt[3:0] = irq_stat_r;
      prog_flag_pkg::REG_IRQ_MASK: rdata_nxt[3:0] = irq_mask_r;
      default: rdata_nxt = '0;
    endcase
  end

  // read data only in the cycle after the strobe
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_rdata <= '0;
    end else if (i_clk_en) begin
      o_rdata <= i_rd_stb ? rdata_nxt : '0;
    end
  end

  // ==========================================================
  // assertions
  // ==========================================================
  a_afull_sync_edge: assert property (@(posedge i_sys_clk) disable iff
    (!i_resetn) tsel_r && !$past(mrst_act) && $changed(o_almost_full_flag_n)
    |-> $past(wedge)) else $error("sync almost-full off write edge");
  a_aempty_sync_edge: assert property (@(posedge i_sys_clk) disable iff
    (!i_resetn) tsel_r && !$past(mrst_act) && $changed(o_almost_empty_flag_n)
    |-> $past(redge)) else $error("sync almost-empty off read edge");
  a_afull_sync_value: assert property (@(posedge i_sys_clk) disable iff
    (!i_resetn) tsel_r && !mrst_act && wedge |=> o_almost_full_flag_n ==
    !$past(full_cond)) else $error("sync almost-full wrong value");
  a_aempty_sync_value: assert property (@(posedge i_sys_clk) disable iff
    (!i_resetn) tsel_r && !mrst_act && redge |=> o_almost_empty_flag_n ==
    !$past(empty_cond)) else $error("sync almost-empty wrong value");
  a_afull_async_edges: assert property (@(posedge i_sys_clk) disable iff
    (!i_resetn) !tsel_r && !$past(mrst_act) && i_clk_en
    |-> ($fell(o_almost_full_flag_n) |-> $past(wedge)) and
        ($rose(o_almost_full_flag_n) |-> $past(redge)))
    else $error("async almost-full on wrong edge");
  a_aempty_async_edges: assert property (@(posedge i_sys_clk) disable iff
    (!i_resetn) !tsel_r && !$past(mrst_act) && i_clk_en
    |-> ($fell(o_almost_empty_flag_n) |-> $past(redge)) and
        ($rose(o_almost_empty_flag_n) |-> $past(wedge)))
    else $error("async almost-empty on wrong edge");
  a_async_rd_std: assert property (@(posedge i_sys_clk) disable iff
    (!i_resetn) o_async_read_active |-> !fall_r)
    else $error("async read port in fall-through");
  a_depth_plus_one: assert property (@(posedge i_sys_clk) disable iff
    (!i_resetn) depth_d[0] == fall_r)
    else $error("fall-through depth not one larger");
  a_serial_wrap: assert property (@(posedge i_sys_clk) disable iff
    (!i_resetn) ser_ev && !mrst_act && bit_r == ser_bits - 5'h01
    |=> bit_r == '0 && ser_half_r != $past(ser_half_r))
    else $error("serial load bit count wrong");
  a_par_steps: assert property (@(posedge i_sys_clk) disable iff
    (!i_resetn) wstep_r <= par_last)
    else $error("parallel step beyond width limit");

endmodule

//--- rtl/prog_flag_pkg.sv
// constants for the programmable almost-full / almost-empty flag unit
package prog_flag_pkg;
  // sampled pin vector layout
  localparam int PIN_W = 34;
  localparam int P_MRST = 0;
  localparam int P_FTSEL = 1;
  localparam int P_FALL = 2;
  localparam int P_X9IN = 3;
  localparam int P_X9OUT = 4;
  localparam int P_ASRD = 5;
  localparam int P_WCLK = 6;
  localparam int P_RCLK = 7;
  localparam int P_WEN = 8;
  localparam int P_REN = 9;
  localparam int P_LD = 10;
  localparam int P_SEN = 11;
  localparam int P_SIN = 12;
  localparam int P_DSEL = 13;
  localparam int P_DATA = 16;
  // widths
  localparam int CNT_W = 18;
  localparam int DATA_W = 18;
  localparam int BYTE_W = 9;
  localparam int DSEL_W = 3;
  localparam int ADDR_W = 5;
  localparam int STEP_W = 2;
  localparam int BIT_W = 5;
  // depth of the smallest variant per bus width
  localparam logic [CNT_W-1:0] DEPTH_BASE_X18 = 18'h00200;
  localparam logic [CNT_W-1:0] DEPTH_BASE_X9 = 18'h00400;
  // serial bit count of the smallest variant per width mode
  localparam logic [BIT_W-1:0] SER_BITS_X9 = 5'h09;
  localparam logic [BIT_W-1:0] SER_BITS_OTHER = 5'h08;
  // offsets restored by master reset
  localparam logic [CNT_W-1:0] OFS_DEFAULT = 18'h0007;
  // index of the last parallel load step per offset pair
  localparam logic [STEP_W-1:0] PAR_LAST_X18 = 2'h1;
  localparam logic [STEP_W-1:0] PAR_LAST_X9 = 2'h3;
  // register byte addresses
  localparam logic [ADDR_W-1:0] REG_STATUS = 5'h00;
  localparam logic [ADDR_W-1:0] REG_LEVEL = 5'h04;
  localparam logic [ADDR_W-1:0] REG_EMPTY_OFS = 5'h08;
  localparam logic [ADDR_W-1:0] REG_FULL_OFS = 5'h0c;
  localparam logic [ADDR_W-1:0] REG_IRQ_STAT = 5'h10;
  localparam logic [ADDR_W-1:0] REG_IRQ_MASK = 5'h14;
  // interrupt bits
  localparam int IRQ_W = 4;
  localparam int IRQ_AFULL = 0;
  localparam int IRQ_AEMPTY = 1;
  localparam int IRQ_LOAD = 2;
  localparam int IRQ_OVF = 3;
endpackage

//--- bench/fifo_side_model.sv
// far-side writer and reader logic driving the flag unit's pins
`timescale 1ns/1ps
module fifo_side_model (
  input wire logic i_sys_clk,
  output logic o_wr_clk,
  output logic o_rd_clk,
  output logic o_wr_en_n,
  output logic o_rd_en_n,
  output logic o_load_n,
  output logic o_serial_en_n,
  output logic o_serial_in,
  output logic [17:0] o_wr_data
);
  // pin clocks stand low between operations
  initial begin
    o_wr_clk = 1'b0;
    o_rd_clk = 1'b0;
    o_wr_en_n = 1'b1;
    o_rd_en_n = 1'b1;
    o_load_n = 1'b1;
    o_serial_en_n = 1'b1;
    o_serial_in = 1'b0;
    o_wr_data = 18'h00000;
  end
  // ============================================================
  // pin clock pulse
  // controls held four cycles either side: the unit samples late
  task automatic pulse(input logic wr);
    repeat (4) @(posedge i_sys_clk);
    if (wr) o_wr_clk <= 1'b1;
    else o_rd_clk <= 1'b1;
    repeat (4) @(posedge i_sys_clk);
    o_wr_clk <= 1'b0;
    o_rd_clk <= 1'b0;
    repeat (4) @(posedge i_sys_clk);
  endtask
  // one word moved, or an idle tick when en is low
  task automatic xfer(input logic wr, input logic en);
    @(posedge i_sys_clk);
    o_wr_en_n <= !(wr && en);
    o_rd_en_n <= !(!wr && en);
    o_wr_data <= ~o_wr_data; // released data toggles
    pulse(wr);
    o_wr_en_n <= 1'b1;
    o_rd_en_n <= 1'b1;
  endtask
  // serial offsets, lsb first, empty then full
  task automatic ser_load(input int nb, input logic [17:0] e,
                          input logic [17:0] f);
    @(posedge i_sys_clk);
    o_load_n <= 1'b0;
    o_serial_en_n <= 1'b0;
    for (int i = 0; i < 2 * nb; i++) begin
      o_serial_in <= (i < nb) ? e[i] : f[i-nb];
      pulse(1'b1);
    end
    o_load_n <= 1'b1;
    o_serial_en_n <= 1'b1;
    o_serial_in <= ~o_serial_in;
  endtask
  // one parallel offset read step onto the offset data port
  task automatic par_read;
    @(posedge i_sys_clk);
    o_load_n <= 1'b0;
    o_rd_en_n <= 1'b0;
    pulse(1'b0);
    o_load_n <= 1'b1;
    o_rd_en_n <= 1'b1;
  endtask
  // parallel offsets: two words at x18, four at x9
  task automatic par_load(input int n, input logic [71:0] ws);
    @(posedge i_sys_clk);
    o_load_n <= 1'b0;
    o_wr_en_n <= 1'b0;
    for (int i = 0; i < n; i++) begin
      o_wr_data <= ws[18*i +: 18];
      pulse(1'b1);
    end
    o_load_n <= 1'b1;
    o_wr_en_n <= 1'b1;
    o_wr_data <= ~o_wr_data;
  endtask
endmodule

//--- bench/fifo_programmable_flag_logic_tb.sv
// self-checking bench for the programmable flag unit
`timescale 1ns/1ps
module fifo_programmable_flag_logic_tb;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic mrn = 1'b1;
  logic tsel = 1'b1;
  logic fall = 1'b0;
  logic x9 = 1'b0;
  logic asr = 1'b0;
  logic [4:0] addr = 5'h00;
  logic [31:0] wdata = 32'h0;
  logic wr_stb = 1'b0;
  logic rd_stb = 1'b0;
  logic [31:0] rdata;
  logic afull_n, aempty_n, irq, wclk, rclk, wen_n, ren_n, ld_n, sen_n, sin;
  logic [17:0] wd;
  logic [17:0] ofs;
  int miscompares = 0;
  int n_tests = 0;
  always #2.5 clk = ~clk;
  prog_flag_unit dut (.i_sys_clk(clk), .i_resetn(resetn),
    .i_clk_en(1'b1), .i_master_reset_n(mrn),
    .i_flag_timing_select(tsel), .i_fall_through_timing(fall),
    .i_x9_in(x9), .i_x9_out(x9), .i_async_read_req(asr),
    .i_depth_sel(3'h0), .i_wr_clk(wclk), .i_rd_clk(rclk),
    .i_wr_en_n(wen_n), .i_rd_en_n(ren_n), .i_load_n(ld_n),
    .i_serial_en_n(sen_n), .i_serial_in(sin), .i_wr_data(wd),
    .i_addr(addr), .i_wdata(wdata), .i_wr_stb(wr_stb),
    .i_rd_stb(rd_stb), .o_rdata(rdata), .o_ofs_data(ofs),
    .o_almost_full_flag_n(afull_n), .o_almost_empty_flag_n(aempty_n),
    .o_async_read_active(), .o_irq(irq));
  fifo_side_model p (.i_sys_clk(clk), .o_wr_clk(wclk),
    .o_rd_clk(rclk), .o_wr_en_n(wen_n), .o_rd_en_n(ren_n),
    .o_load_n(ld_n), .o_serial_en_n(sen_n), .o_serial_in(sin),
    .o_wr_data(wd));
  // ============================================================
  // shared helpers
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic summarize;
    $display("compares %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // read data stands only in the cycle after the strobe
  task automatic rchk(input logic [4:0] a, input logic [31:0] exp);
    @(posedge clk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge clk);
    rd_stb <= 1'b0;
    #1 chk(rdata, exp);
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge clk);
    wr_stb <= 1'b0;
  endtask
  // straps are captured only while master reset is low
  task automatic mr(input logic s, input logic f, input logic n,
                    input logic a);
    @(posedge clk);
    mrn <= 1'b0;
    tsel <= s;
    fall <= f;
    x9 <= n;
    asr <= a;
    repeat (8) @(posedge clk);
    mrn <= 1'b1;
    repeat (8) @(posedge clk);
  endtask
  // ============================================================
  // scenarios
  task automatic t_regs;
    mr(1'b1, 1'b0, 1'b0, 1'b1);
    rchk(prog_flag_pkg::REG_STATUS, 32'h65);
    rchk(5'h1c, 32'h0);
    wr(prog_flag_pkg::REG_IRQ_MASK, 32'hf);
    rchk(prog_flag_pkg::REG_IRQ_MASK, 32'hf);
    rchk(prog_flag_pkg::REG_LEVEL, 32'h0);
    $display("test regs done");
  endtask
  // async flags; almost-empty rises on the write edge past offset 7
  task automatic t_async;
    mr(1'b0, 1'b1, 1'b0, 1'b1);
    rchk(prog_flag_pkg::REG_STATUS, 32'h29);
    wr(prog_flag_pkg::REG_IRQ_MASK, 32'h2);
    for (int i = 0; i < 7; i++) p.xfer(1'b1, 1'b1);
    chk(aempty_n, 32'h0);
    p.xfer(1'b1, 1'b1);
    chk(aempty_n, 32'h1);
    chk(irq, 32'h0);
    p.xfer(1'b0, 1'b1);
    chk(aempty_n, 32'h0);
    chk(irq, 32'h1);
    wr(prog_flag_pkg::REG_IRQ_STAT, 32'h2);
    @(posedge clk);
    #1 chk(irq, 32'h0);
    $display("test async done");
  endtask
  // fall-through depth 513 with full offset 255 needs 258 words
  task automatic t_sync_fall_through_timing;
    mr(1'b1, 1'b1, 1'b0, 1'b0);
    p.ser_load(8, 18'h00003, 18'h000ff);
    rchk(prog_flag_pkg::REG_EMPTY_OFS, 32'h3);
    rchk(prog_flag_pkg::REG_FULL_OFS, 32'hff);
    for (int i = 0; i < 257; i++) p.xfer(1'b1, 1'b1);
    chk(afull_n, 32'h1);
    chk(aempty_n, 32'h0);
    p.xfer(1'b1, 1'b1);
    chk(afull_n, 32'h0);
    p.xfer(1'b0, 1'b1);
    chk(afull_n, 32'h0);
    chk(aempty_n, 32'h1);
    p.xfer(1'b1, 1'b0);
    chk(afull_n, 32'h1);
    rchk(prog_flag_pkg::REG_LEVEL, 32'h101);
    $display("test sync fall_through_timing done");
  endtask
  // x9 needs two writes per offset, x18 one
  task automatic t_par;
    mr(1'b1, 1'b0, 1'b1, 1'b0);
    rchk(prog_flag_pkg::REG_STATUS, 32'h15);
    p.par_load(4, {18'h1, 18'h23, 18'h0, 18'h5});
    rchk(prog_flag_pkg::REG_EMPTY_OFS, 32'h5);
    rchk(prog_flag_pkg::REG_FULL_OFS, 32'h223);
    mr(1'b1, 1'b0, 1'b0, 1'b0);
    p.par_load(2, {36'h0, 18'h22, 18'h11});
    rchk(prog_flag_pkg::REG_EMPTY_OFS, 32'h11);
    rchk(prog_flag_pkg::REG_FULL_OFS, 32'h22);
    p.par_read();
    chk(ofs, 32'h11);
    p.par_read();
    chk(ofs, 32'h22);
    $display("test parallel done");
  endtask
  // ============================================================
  // watchdog against a hang
  initial begin
    repeat (60000) @(posedge clk);
    miscompares++;
    summarize();
  end
  // main sequence
  initial begin
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    t_regs();
    t_async();
    t_sync_fall_through_timing();
    t_par();
    summarize();
  end
endmodule
